// >>> hw/odf_ctrl.sv
/*
 * output delay and fail-safe controller: four delayed outputs, two idle
 * watchdogs, fail-safe override, locate indication and a register port.
 * assumes a 10 MHz clock, synchronous packet pulses from the network
 * side and a master that follows the one-cycle strobe protocol.
 */
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "odf_defs.svh"

module odf_ctrl
	import odf_pkg::*;
#(
	parameter int LOCATE_TICKS = `ODF_LOCATE_TICKS  // locate time in 0.1 ms ticks
) (
	input  wire logic        clk_sys_in,       // system clock, 10 MHz
	input  wire logic        rst_n_in,         // async reset, active low
	input  wire logic [7:0]  addr_in,          // register byte address
	input  wire logic [31:0] wr_data_in,       // write data
	input  wire logic        wr_in,            // write strobe
	input  wire logic        rd_in,            // read strobe
	output logic      [31:0] rd_data_out,      // read data, cycle after strobe
	input  wire logic        host_pkt_in,      // host packet received
	input  wire logic        peer_pkt_in,      // peer or logic-rule packet received
	input  wire logic        status_led_in,    // normal status indication
	output logic      [3:0]  dout_out,         // output channels
	output logic             led_out,          // status LED
	output logic             safety_send_out,  // request to send safety values
	output logic      [3:0]  safety_val_out,   // safety values to send
	output logic             irq_out           // interrupt, active high level
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	// true when the bus address hits a register
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_off);
		hit = (a == reg_off);
	endfunction

	// mode field of one channel
	function automatic odf_mode_e mode_of(input logic [7:0] m, input int ch);
		mode_of = odf_mode_e'(m[2*ch +: 2]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic        comm_en;                    // comm watchdog armed
	logic        peer_en;                    // peer watchdog armed
	logic [7:0]  mode_reg;                   // two mode bits per channel
	logic [3:0]  cmd_reg;                    // commanded levels
	logic [15:0] delay_mem [0:`ODF_NCH-1];   // delay per channel, ticks
	logic [3:0]  fs_pend;                    // written fail-safe bits
	logic [3:0]  fs_act;                     // applied fail-safe bits
	logic [15:0] host_idle;                  // host idle time, ticks
	logic [15:0] peer_idle;                  // peer idle time, ticks
	logic [2:0]  irq_stat;                   // sticky events
	logic [2:0]  irq_mask;                   // event enables
	logic [9:0]  tick_cnt;                   // time base divider
	logic        tick;                       // 0.1 ms pulse
	odf_loc_e    loc_state;                  // locate sequencer
	logic [16:0] loc_cnt;                    // locate elapsed ticks
	logic        loc_done;                   // locate ended this cycle
	logic [3:0]  chan_level;                 // delayed channel levels
	logic        wr_ctrl;                    // write to control register
	logic        locate_go;                  // locate start pulse
	logic        apply_fs;                   // fail-safe apply pulse
	logic        rearm;                      // watchdog re-arm pulse
	logic        irq_rd;                     // read clears status
	logic [2:0]  irq_set;                    // events of this cycle
	logic [31:0] next_rd_data;               // read mux
	logic [3:0]  next_dout;                  // output select

	odf_wdt_if comm_wdt ();                  // host watchdog link
	odf_wdt_if peer_wdt ();                  // peer watchdog link

	////////////////////////////////////////////////////////////////////////
	// strobe decode

	// command bits of the control register act as one-cycle pulses
	always_comb begin
		wr_ctrl   = wr_in && hit(addr_in, `ODF_REG_CTRL);
		locate_go = wr_ctrl && wr_data_in[`ODF_CTRL_LOCATE];
		apply_fs  = wr_ctrl && wr_data_in[`ODF_CTRL_APPLY_FS];
		rearm     = wr_ctrl && wr_data_in[`ODF_CTRL_REARM];
		irq_rd    = rd_in && hit(addr_in, `ODF_REG_IRQ_STAT);
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	// enables, modes, commands and idle times
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			comm_en   <= 1'b0;
			peer_en   <= 1'b0;
			mode_reg  <= `ODF_RST_MODE;
			cmd_reg   <= 4'h0;
			host_idle <= `ODF_RST_IDLE;
			peer_idle <= `ODF_RST_IDLE;
			irq_mask  <= 3'h0;
		end else if (wr_in) begin
			if (wr_ctrl) begin
				comm_en <= wr_data_in[`ODF_CTRL_COMM_EN];
				peer_en <= wr_data_in[`ODF_CTRL_PEER_EN];
			end
			if (hit(addr_in, `ODF_REG_MODE)) begin
				mode_reg <= wr_data_in[7:0];
			end
			if (hit(addr_in, `ODF_REG_CMD)) begin
				// level commands are taken in every mode
				cmd_reg <= wr_data_in[3:0];
			end
			if (hit(addr_in, `ODF_REG_HOST_IDLE)) begin
				host_idle <= wr_data_in[15:0];
			end
			if (hit(addr_in, `ODF_REG_PEER_IDLE)) begin
				peer_idle <= wr_data_in[15:0];
			end
			if (hit(addr_in, `ODF_REG_IRQ_MASK)) begin
				irq_mask <= wr_data_in[2:0];
			end
		end
	end

	// delay table, one word per channel
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `ODF_NCH; i++) begin
				delay_mem[i] <= `ODF_RST_DELAY;
			end
		end else if (wr_in && (addr_in[7:4] == 4'(`ODF_REG_DELAY_BASE >> 4))) begin
			delay_mem[addr_in[3:2]] <= wr_data_in[15:0];
		end
	end

	// fail-safe bits: written ones wait for the apply command
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fs_pend <= 4'h0;
			fs_act  <= 4'h0;
		end else begin
			if (wr_in && hit(addr_in, `ODF_REG_FS_PEND)) begin
				fs_pend <= wr_data_in[3:0];
			end
			if (apply_fs) begin
				fs_act <= fs_pend;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// time base

	// one pulse every 0.1 ms
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt <= 10'h000;
			tick     <= 1'b0;
		end else if (tick_cnt == 10'(`ODF_TICK_CYCLES - 1)) begin
			tick_cnt <= 10'h000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 10'h001;
			tick     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output channels

	// each channel delays its own edges; generate keeps one instance each
	for (genvar g = 0; g < `ODF_NCH; g++) begin : g_chan
		odf_delay_chan u_chan (
			.clk_sys_in (clk_sys_in),
			.rst_n_in   (rst_n_in),
			.tick_in    (tick),
			.mode_in    (mode_of(mode_reg, g)),
			.cmd_in     (cmd_reg[g]),
			.delay_in   (delay_mem[g]),
			.level_out  (chan_level[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// watchdogs

	// host traffic watchdog and peer link watchdog
	always_comb begin
		comm_wdt.enable = comm_en;
		comm_wdt.tick   = tick;
		comm_wdt.kick   = host_pkt_in;
		comm_wdt.rearm  = rearm;
		comm_wdt.idle   = host_idle;
		peer_wdt.enable = peer_en;
		peer_wdt.tick   = tick;
		peer_wdt.kick   = peer_pkt_in;
		peer_wdt.rearm  = rearm;
		peer_wdt.idle   = peer_idle;
	end

	odf_idle_wdt u_comm_wdt (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.bus        (comm_wdt)
	);

	odf_idle_wdt u_peer_wdt (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.bus        (peer_wdt)
	);

	// fail-safe override of the outputs while the host link is lost
	always_comb begin
		next_dout = comm_wdt.timeout ? fs_act : chan_level;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dout_out <= 4'h0;
		end else begin
			dout_out <= next_dout;
		end
	end

	// peer timeout asks the network side to send the applied safety values
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			safety_send_out <= 1'b0;
			safety_val_out  <= 4'h0;
		end else begin
			safety_send_out <= peer_wdt.expire;
			if (peer_wdt.expire) begin
				safety_val_out <= fs_act;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// locate

	// led held on for the locate time, a new start restarts it
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			loc_state <= ODF_LOC_IDLE;
			loc_cnt   <= 17'h00000;
			loc_done  <= 1'b0;
		end else begin
			loc_done <= 1'b0;
			case (loc_state)
				ODF_LOC_IDLE: begin
					loc_cnt <= 17'h00000;
					if (locate_go) begin
						loc_state <= ODF_LOC_ON;
					end
				end
				ODF_LOC_ON: begin
					if (locate_go) begin
						loc_cnt <= 17'h00000;
					end else if (tick) begin
						if (loc_cnt == 17'(LOCATE_TICKS - 1)) begin
							// time is up, back to normal indication
							loc_state <= ODF_LOC_IDLE;
							loc_done  <= 1'b1;
						end else begin
							loc_cnt <= loc_cnt + 17'h00001;
						end
					end
				end
				default: begin
					loc_state <= ODF_LOC_IDLE;
				end
			endcase
		end
	end

	// status led: locate wins over normal indication
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			led_out <= 1'b0;
		end else begin
			led_out <= (loc_state == ODF_LOC_ON) ? 1'b1 : status_led_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts

	// sticky events, a read clears them but a new event wins
	always_comb begin
		irq_set = 3'h0;
		irq_set[`ODF_IRQ_COMM]   = comm_wdt.expire;
		irq_set[`ODF_IRQ_PEER]   = peer_wdt.expire;
		irq_set[`ODF_IRQ_LOCATE] = loc_done;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_stat <= 3'h0;
			irq_out  <= 1'b0;
		end else begin
			irq_stat <= (irq_rd ? 3'h0 : irq_stat) | irq_set;
			irq_out  <= |(((irq_rd ? 3'h0 : irq_stat) | irq_set) & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port

	// read mux, unmapped addresses read zero
	always_comb begin
		next_rd_data = 32'h00000000;
		if (addr_in[7:4] == 4'(`ODF_REG_DELAY_BASE >> 4)) begin
			next_rd_data[15:0] = delay_mem[addr_in[3:2]];
		end else begin
			case (addr_in)
				`ODF_REG_CTRL: begin
					next_rd_data[`ODF_CTRL_COMM_EN] = comm_en;
					next_rd_data[`ODF_CTRL_PEER_EN] = peer_en;
				end
				`ODF_REG_MODE:      next_rd_data[7:0]  = mode_reg;
				`ODF_REG_CMD:       next_rd_data[3:0]  = cmd_reg;
				`ODF_REG_STATUS: begin
					next_rd_data[3:0]             = dout_out;
					next_rd_data[`ODF_ST_COMM_TO] = comm_wdt.timeout;
					next_rd_data[`ODF_ST_PEER_TO] = peer_wdt.timeout;
					next_rd_data[`ODF_ST_LOCATE]  = (loc_state == ODF_LOC_ON);
				end
				`ODF_REG_FS_PEND:   next_rd_data[3:0]  = fs_pend;
				`ODF_REG_FS_ACT:    next_rd_data[3:0]  = fs_act;
				`ODF_REG_HOST_IDLE: next_rd_data[15:0] = host_idle;
				`ODF_REG_PEER_IDLE: next_rd_data[15:0] = peer_idle;
				`ODF_REG_IRQ_STAT:  next_rd_data[2:0]  = irq_stat;
				`ODF_REG_IRQ_MASK:  next_rd_data[2:0]  = irq_mask;
				default:            next_rd_data       = 32'h00000000;
			endcase
		end
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= 32'h00000000;
		end else begin
			rd_data_out <= rd_in ? next_rd_data : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	fs_force_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		comm_wdt.timeout |=> (dout_out == $past(fs_act)))
		else $error("outputs not at fail-safe level on timeout");
	fs_apply_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!apply_fs |=> $stable(fs_act))
		else $error("fail-safe bits changed without apply");
	fs_take_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		apply_fs |=> (fs_act == $past(fs_pend)))
		else $error("apply did not take pending bits");
	locate_led_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(loc_state == ODF_LOC_ON) |=> led_out)
		else $error("led dark during locate");
	locate_len_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		loc_done |-> $past(loc_cnt) == 17'(LOCATE_TICKS - 1))
		else $error("locate ended at wrong time");
	safety_send_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		peer_wdt.expire |=> safety_send_out && (safety_val_out == $past(fs_act)))
		else $error("peer timeout did not send safety values");
endmodule

// >>> hw/odf_defs.svh
/*
 * register offsets, field positions, reset values and timing counts of the
 * output delay and fail-safe controller.
 * assumes a 10 MHz system clock and a byte-addressed 32-bit register port.
 */
`ifndef ODF_DEFS_SVH
`define ODF_DEFS_SVH

// channel count and field widths
`define ODF_NCH             4
`define ODF_DLY_W           16

// register byte offsets
`define ODF_REG_CTRL        8'h00
`define ODF_REG_MODE        8'h04
`define ODF_REG_CMD         8'h08
`define ODF_REG_STATUS      8'h0c
`define ODF_REG_DELAY_BASE  8'h10
`define ODF_REG_FS_PEND     8'h20
`define ODF_REG_FS_ACT      8'h24
`define ODF_REG_HOST_IDLE   8'h28
`define ODF_REG_PEER_IDLE   8'h2c
`define ODF_REG_IRQ_STAT    8'h30
`define ODF_REG_IRQ_MASK    8'h34

// control register bit positions
`define ODF_CTRL_COMM_EN    0
`define ODF_CTRL_PEER_EN    1
`define ODF_CTRL_LOCATE     2
`define ODF_CTRL_APPLY_FS   3
`define ODF_CTRL_REARM      4

// status and interrupt bit positions
`define ODF_ST_COMM_TO      4
`define ODF_ST_PEER_TO      5
`define ODF_ST_LOCATE       6
`define ODF_IRQ_COMM        0
`define ODF_IRQ_PEER        1
`define ODF_IRQ_LOCATE      2

// reset values
`define ODF_RST_IDLE        16'h0064
`define ODF_RST_DELAY       16'h0000
`define ODF_RST_MODE        8'h00

// timing
`define ODF_CLK_PERIOD_NS   100
`define ODF_TICK_TIME_NS    100000
`define ODF_TICK_CYCLES     (`ODF_TICK_TIME_NS / `ODF_CLK_PERIOD_NS)
`define ODF_LOCATE_TIME_MS  10000
`define ODF_LOCATE_TICKS    (`ODF_LOCATE_TIME_MS * 10)

`endif

// >>> hw/odf_delay_chan.sv
/*
 * one output channel with optional rising or falling edge delay.
 * assumes a one-cycle tick every 0.1 ms and a steady mode and delay.
 */
`timescale 1ns/10ps

module odf_delay_chan
	import odf_pkg::*;
(
	input  wire logic        clk_sys_in,  // system clock
	input  wire logic        rst_n_in,    // async reset, active low
	input  wire logic        tick_in,     // 0.1 ms pulse
	input  wire odf_mode_e   mode_in,     // channel mode
	input  wire logic        cmd_in,      // commanded level
	input  wire logic [15:0] delay_in,    // delay in ticks
	output logic             level_out    // delayed level
);

	logic [15:0] cnt;   // elapsed ticks of a pending transition
	logic        held;  // the pending transition is the delayed one

	////////////////////////////////////////////////////////////////////////
	// which transition waits
	always_comb begin
		held = ((mode_in == ODF_RISE) && cmd_in) || ((mode_in == ODF_FALL) && !cmd_in);
	end

	// level follows command, delayed edges wait for the tick count
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_out <= 1'b0;
			cnt       <= 16'h0000;
		end else if (cmd_in == level_out) begin
			// nothing pending, a withdrawn command cancels the wait
			cnt <= 16'h0000;
		end else if (held) begin
			if (cnt >= delay_in) begin
				level_out <= cmd_in;
				cnt       <= 16'h0000;
			end else if (tick_in) begin
				cnt <= cnt + 16'h0001;
			end
		end else begin
			// undelayed edge and direct mode pass at once
			level_out <= cmd_in;
			cnt       <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	rise_wait_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(mode_in == ODF_RISE) && !level_out && (cnt < delay_in) |=> !level_out)
		else $error("rising edge passed before its delay");
	fall_wait_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(mode_in == ODF_FALL) && level_out && (cnt < delay_in) |=> level_out)
		else $error("falling edge passed before its delay");
	direct_cmd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(mode_in == ODF_DIRECT) |=> (level_out == $past(cmd_in)))
		else $error("direct command not followed");
	rise_fall_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(mode_in == ODF_RISE) && level_out && !cmd_in |=> !level_out)
		else $error("undelayed falling edge held in rise mode");
endmodule

// >>> hw/odf_idle_wdt.sv
/*
 * idle watchdog: times out when no packet arrives within the idle time.
 * assumes the tick and kick pulses are one cycle long.
 */
`timescale 1ns/10ps

module odf_idle_wdt (
	input  wire logic clk_sys_in,  // system clock
	input  wire logic rst_n_in,    // async reset, active low
	odf_wdt_if.wdt    bus          // control and result
);

	logic [15:0] cnt;  // ticks since the last packet

	////////////////////////////////////////////////////////////////////////
	// idle counter and timeout flag
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt         <= 16'h0000;
			bus.timeout <= 1'b0;
			bus.expire  <= 1'b0;
		end else begin
			bus.expire <= 1'b0;
			if (!bus.enable || bus.kick || bus.rearm) begin
				// traffic or re-arm restarts the idle time
				cnt         <= 16'h0000;
				bus.timeout <= 1'b0;
			end else if (bus.tick && !bus.timeout) begin
				if (cnt >= bus.idle) begin
					// elapsed time now exceeds the idle time
					bus.timeout <= 1'b1;
					bus.expire  <= 1'b1;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	idle_expire_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		bus.enable && !bus.kick && !bus.rearm && bus.tick && !bus.timeout
		&& (cnt >= bus.idle) |=> bus.timeout && bus.expire)
		else $error("watchdog missed its idle time");
	kick_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		bus.kick |=> !bus.timeout && (cnt == 16'h0000))
		else $error("packet did not restart watchdog");
	timeout_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		bus.timeout && bus.enable && !bus.kick && !bus.rearm |=> bus.timeout)
		else $error("timeout dropped without traffic");
endmodule

// >>> hw/odf_pkg.sv
/*
 * types shared by the output delay and fail-safe controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package odf_pkg;

	// output mode of one channel, two bits in the mode register
	typedef enum logic [1:0] {
		ODF_DIRECT,
		ODF_RISE,
		ODF_FALL,
		ODF_SPARE
	} odf_mode_e;

	// locate sequencer states
	typedef enum logic {
		ODF_LOC_IDLE,
		ODF_LOC_ON
	} odf_loc_e;

endpackage

// >>> hw/odf_wdt_if.sv
/*
 * interface between the controller and one idle watchdog.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/10ps

interface odf_wdt_if;
	logic        enable;   // watchdog armed
	logic        tick;     // 0.1 ms time base pulse
	logic        kick;     // qualifying packet received
	logic        rearm;    // software clears a standing timeout
	logic [15:0] idle;     // allowed idle time in ticks
	logic        timeout;  // standing timeout level
	logic        expire;   // one-cycle pulse as the timeout starts

	modport wdt (input enable, input tick, input kick, input rearm, input idle,
		output timeout, output expire);
	modport ctl (output enable, output tick, output kick, output rearm, output idle,
		input timeout, input expire);
endinterface

// >>> tb/odf_host_model.sv
/*
 * network host model: sends host and peer packet pulses, logs safety sends.
 * assumes the controller's clock and reset.
 */
`timescale 1ns/10ps

module odf_host_model (
	input  wire logic       clk_sys_in,     // system clock
	input  wire logic       rst_n_in,       // async reset, active low
	input  wire logic       host_en_in,     // host traffic on
	input  wire logic       peer_en_in,     // peer traffic on
	input  wire logic       safety_send_in, // safety values sent to us
	input  wire logic [3:0] safety_val_in,  // safety values
	output logic            host_pkt_out,   // host packet pulse
	output logic            peer_pkt_out,   // peer packet pulse
	output int              n_sends_out,    // safety sends seen
	output logic      [3:0] last_val_out    // last safety value seen
);
	int gap; // cycles since last packet
	// one packet every 500 cycles, well inside any idle time used
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gap <= 0;
			host_pkt_out <= 1'b0;
			peer_pkt_out <= 1'b0;
			n_sends_out <= 0;
			last_val_out <= 4'h0;
		end else begin
			gap <= (gap == 499) ? 0 : gap + 1;
			host_pkt_out <= host_en_in && gap == 499;
			peer_pkt_out <= peer_en_in && gap == 499;
			if (safety_send_in) begin
				n_sends_out <= n_sends_out + 1;
				last_val_out <= safety_val_in;
			end
		end
	end
endmodule

// >>> tb/tb_top.sv
/*
 * self-checking bench of the output delay and fail-safe controller.
 * assumes a 10 MHz clock and the host model beside the design.
 */
`timescale 1ns/10ps

module tb_top;
	logic clk_sys_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0, status_led_in = 0;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wr_data_in = 32'h0, rd_data_out, r;
	logic host_pkt_in, peer_pkt_in, led_out, safety_send_out, irq_out;
	logic [3:0]  dout_out, safety_val_out, last_val, fs;
	logic host_en = 0, peer_en = 0;
	int   n_sends, n_errors = 0, compares = 0, n;

	always #50 clk_sys_in = ~clk_sys_in;

	odf_ctrl #(.LOCATE_TICKS(3)) u_dut (.clk_sys_in, .rst_n_in, .addr_in,
		.wr_data_in, .wr_in, .rd_in, .rd_data_out, .host_pkt_in, .peer_pkt_in,
		.status_led_in, .dout_out, .led_out, .safety_send_out, .safety_val_out,
		.irq_out);
	odf_host_model u_host (.clk_sys_in, .rst_n_in, .host_en_in(host_en),
		.peer_en_in(peer_en), .safety_send_in(safety_send_out),
		.safety_val_in(safety_val_out), .host_pkt_out(host_pkt_in),
		.peer_pkt_out(peer_pkt_in), .n_sends_out(n_sends), .last_val_out(last_val));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		d = rd_data_out;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
	endtask
	task automatic complete_run;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// cuts a hang short
	initial begin
		#(100 * 40000);
		n_errors++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(77));
		n = 2 + $urandom % 3; // two ticks or more, so the early look precedes any edge
		fs = 4'(1 + $urandom % 15);
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		// reset values and unmapped place
		rd(8'h28, r); chk("host_idle", 32'h64, r);
		rd(8'h34, r); chk("irq_mask", 32'h0, r);
		rd(8'h3c, r); chk("unmapped", 32'h0, r);
		// ch0 rise delay, ch1 fall delay, ch2 direct
		wr(8'h10, n); wr(8'h14, n); wr(8'h04, 32'h9);
		wr(8'h08, 32'h2); cyc(3); chk("dout", 4'h2, dout_out);
		wr(8'h08, 32'h5); cyc(2); chk("dout", 4'h6, dout_out);
		cyc((n - 1) * 1000 - 2); chk("dout", 4'h6, dout_out);
		cyc(1003); chk("dout", 4'h5, dout_out);
		// fail-safe apply and comm timeout
		wr(8'h04, 32'h0); wr(8'h08, 32'h0); wr(8'h28, 32'h2);
		wr(8'h20, fs); rd(8'h24, r); chk("fs_act", 32'h0, r);
		wr(8'h00, 32'h8); rd(8'h24, r); chk("fs_act", fs, r);
		wr(8'h34, 32'h7); wr(8'h00, 32'h1);
		cyc(1500); chk("dout", 4'h0, dout_out);
		cyc(3000); chk("dout", fs, dout_out);
		// outputs in the low nibble, comm timeout flag at bit 4
		rd(8'h0c, r); chk("status", 32'h10 | 32'(fs), r);
		chk("irq", 1'b1, irq_out);
		rd(8'h30, r); chk("irq_stat", 32'h1, r);
		cyc(2); chk("irq", 1'b0, irq_out);
		// re-arm drops the standing timeout at once
		wr(8'h00, 32'h11); cyc(3); chk("dout", 4'h0, dout_out);
		host_en <= 1'b1;
		cyc(600); chk("dout", 4'h0, dout_out);
		// peer watchdog sends safety values
		wr(8'h2c, 32'h1); wr(8'h00, 32'h3);
		cyc(3200); chk("sends", 1'b1, n_sends > 0);
		chk("safety_val", fs, last_val);
		// locate lights the led, then the status shows again
		wr(8'h00, 32'h7); cyc(3); chk("led", 1'b1, led_out);
		cyc(4200); chk("led", 1'b0, led_out);
		@(posedge clk_sys_in);
		status_led_in <= 1'b1;
		cyc(2); chk("led", 1'b1, led_out);
		rd(8'h30, r); chk("irq_locate", 1'b1, r[2]);
		complete_run();
	end
endmodule
